// *** fec_blk_src.sv ***
// model of the transceiver data path sending decoded fec blocks.
// assumes send is called just after a rising clock edge.
`timescale 1ns/1ps
module fec_blk_src (
	input wire clk_i,
	output logic valid_o,
	output logic good_o,
	output logic uncorr_o
);
	initial begin
		valid_o = 1'b0;
		good_o = 1'b0;
		uncorr_o = 1'b0;
	end
	// qualifiers flip outside blocks so stale values never look valid
	task send(input logic g, input logic u, input int n);
		repeat (n) begin
			valid_o <= 1'b1;
			good_o <= g;
			uncorr_o <= u;
			@(posedge clk_i);
		end
		valid_o <= 1'b0;
		good_o <= ~g;
		uncorr_o <= ~u;
		repeat (3) @(posedge clk_i);
	endtask
endmodule // fec_blk_src

// *** fec_block_lock_options.v ***
// top of the optional fec sublayer lock and option logic.
// assumes the transceiver data path delivers one blk_valid_i pulse per
// fec block with parity and decode results, and an apb3 master on the
// same clock drives the register port.
`timescale 1ns/1ps
`include "fec_lock_consts.vh"
module fec_block_lock_options #(
	parameter INCLUDE_FEC = 1,
	parameter SET_ABILITY = 1,
	parameter SET_ENABLE = 1,
	parameter SET_ERR_REPORT = 1,
	parameter EXTRA_PINS = 1,
	parameter TW = 8,
	parameter [TW-1:0] GOOD_THRESH = `GOOD_THRESH_DEF,
	parameter [TW-1:0] BAD_THRESH = `BAD_THRESH_DEF
) (
	input wire mclk_i,
	input wire srst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire blk_valid_i,
	input wire parity_good_i,
	input wire uncorr_i,
	output wire slip_o,
	output wire soft_pcs_sel_o,
	output wire correction_active_o,
	output reg err_report_o,
	output wire block_lock_o,
	output wire high_error_rate_status_o,
	output wire irq_o
);

// ----------------------------------------
// helpers
// ----------------------------------------
// saturating increment, used by the error counters
function [31:0] sat_inc;
	input [31:0] v;
	input [31:0] top;
	begin
		if (v >= top)
			sat_inc = top;
		else
			sat_inc = v + 32'h00000001;
	end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg correction_ability_flag;
reg correction_enable_flag;
reg correction_error_report_flag;
reg [`INT_BITS-1:0] int_status;
reg [`INT_BITS-1:0] int_mask;
reg [TW-1:0] good_thresh;
reg [TW-1:0] bad_thresh;
reg [15:0] uncorr_cnt;
reg [7:0] hiber_win;
reg [7:0] hiber_limit;
reg [7:0] win_cnt;
reg [7:0] bad_in_win;
reg high_error_rate;
reg lock_prev;
reg hiber_prev;
reg [31:0] rdata;
reg slverr;
reg [`INT_BITS-1:0] next_int_status;

wire fec_lock;
wire fec_present = (INCLUDE_FEC != 0);
wire fec_on;
wire setup = psel_i & ~penable_i;
wire access = psel_i & penable_i;
wire wr = access & pwrite_i;
wire rd_int = access & ~pwrite_i & (paddr_i == `OFS_INT_STATUS);
wire blk_bad = blk_valid_i & ~parity_good_i;
wire [31:0] bad_inc = sat_inc({24'h000000, bad_in_win}, 32'h000000FF);
wire [31:0] uncorr_inc = sat_inc({16'h0000, uncorr_cnt}, 32'h0000FFFF);
wire [`INT_BITS-1:0] events;

// correction only with the soft pcs path
assign soft_pcs_sel_o = fec_present;
assign fec_on = fec_present & correction_enable_flag;
assign correction_active_o = fec_on;

// ----------------------------------------
// control flags
// ----------------------------------------
// the flags reset to their option values, then software may change them
always @(posedge mclk_i) begin
	if (srst_i) begin
		correction_ability_flag <= (SET_ABILITY != 0) & fec_present;
		correction_enable_flag <= (SET_ENABLE != 0) & fec_present;
		correction_error_report_flag <= (SET_ERR_REPORT != 0);
	end else if (wr && paddr_i == `OFS_CTRL) begin
		correction_ability_flag <= pwdata_i[`CTRL_ABILITY] & fec_present;
		// enabling needs the ability, so a stale enable cannot stick
		correction_enable_flag <= pwdata_i[`CTRL_ENABLE] & fec_present
			& pwdata_i[`CTRL_ABILITY];
		correction_error_report_flag <= pwdata_i[`CTRL_ERR_REPORT];
	end
end

// ----------------------------------------
// thresholds and high error rate config
// ----------------------------------------
always @(posedge mclk_i) begin
	if (srst_i) begin
		good_thresh <= GOOD_THRESH;
		bad_thresh <= BAD_THRESH;
		hiber_win <= `HIBER_WIN_DEF;
		hiber_limit <= `HIBER_LIMIT_DEF;
		int_mask <= `INT_MASK_RST;
	end else if (wr) begin
		case (paddr_i)
		`OFS_THRESH: begin
			good_thresh <= pwdata_i[TW-1:0];
			bad_thresh <= pwdata_i[TW+7:8];
		end
		`OFS_HIBER_CFG: begin
			hiber_win <= pwdata_i[7:0];
			hiber_limit <= pwdata_i[15:8];
		end
		`OFS_INT_MASK: begin
			int_mask <= pwdata_i[`INT_BITS-1:0];
		end
		default: begin
			int_mask <= int_mask;
		end
		endcase
	end
end

// ----------------------------------------
// block lock
// ----------------------------------------
// the hunter sits idle while correction is off
fec_lock_fsm #(
	.TW(TW)
) u_lock (
	.mclk_i(mclk_i),
	.srst_i(srst_i),
	.hold_i(~fec_on),
	.blk_valid_i(blk_valid_i),
	.parity_good_i(parity_good_i),
	.good_thresh_i(good_thresh),
	.bad_thresh_i(bad_thresh),
	.lock_o(fec_lock),
	.slip_o(slip_o)
);

// ----------------------------------------
// high error rate monitor
// ----------------------------------------
// bad parity blocks are counted over a window of hiber_win blocks;
// the verdict moves at window ends and clears at once when lock or correction drops, so it lags by one window
always @(posedge mclk_i) begin
	if (srst_i || !fec_on || !fec_lock) begin
		win_cnt <= 8'h00;
		bad_in_win <= 8'h00;
		high_error_rate <= 1'b0;
	end else if (blk_valid_i) begin
		if (win_cnt + 8'h01 >= hiber_win) begin
			win_cnt <= 8'h00;
			bad_in_win <= 8'h00;
			high_error_rate <= (bad_inc >= {24'h000000, hiber_limit} &&
				blk_bad) || (bad_in_win >= hiber_limit);
		end else begin
			win_cnt <= win_cnt + 8'h01;
			if (blk_bad)
				bad_in_win <= bad_inc[7:0];
		end
	end
end

// ----------------------------------------
// error indication to the pcs
// ----------------------------------------
always @(posedge mclk_i) begin
	if (srst_i) begin
		err_report_o <= 1'b0;
		uncorr_cnt <= 16'h0000;
	end else begin
		err_report_o <= fec_on & correction_error_report_flag &
			blk_valid_i & uncorr_i;
		if (fec_on && blk_valid_i && uncorr_i)
			uncorr_cnt <= uncorr_inc[15:0];
	end
end

// ----------------------------------------
// status outputs
// ----------------------------------------
// optional lock and error rate pins
assign block_lock_o = (EXTRA_PINS != 0) & fec_lock;
assign high_error_rate_status_o = (EXTRA_PINS != 0) & high_error_rate;

// ----------------------------------------
// interrupts
// ----------------------------------------
always @(posedge mclk_i) begin
	if (srst_i) begin
		lock_prev <= 1'b0;
		hiber_prev <= 1'b0;
	end else begin
		lock_prev <= fec_lock;
		hiber_prev <= high_error_rate;
	end
end

assign events[`INT_LOCK_GAIN] = fec_lock & ~lock_prev;
assign events[`INT_LOCK_LOSS] = ~fec_lock & lock_prev;
assign events[`INT_UNCORR] = fec_on & blk_valid_i & uncorr_i;
assign events[`INT_HIBER] = high_error_rate & ~hiber_prev;

// a read clears the bits it returned; an event in that cycle survives
always @* begin
	next_int_status = int_status;
	if (rd_int)
		next_int_status = {`INT_BITS{1'b0}};
	next_int_status = next_int_status | events;
end

always @(posedge mclk_i) begin
	if (srst_i)
		int_status <= {`INT_BITS{1'b0}};
	else
		int_status <= next_int_status;
end

assign irq_o = |(int_status & int_mask);

// ----------------------------------------
// apb read path
// ----------------------------------------
// read data is captured in the setup cycle so prdata comes from flops;
// the slave never inserts wait states
always @(posedge mclk_i) begin
	if (srst_i) begin
		rdata <= 32'h00000000;
		slverr <= 1'b0;
	end else if (setup) begin
		rdata <= 32'h00000000;
		slverr <= 1'b0;
		case (paddr_i)
		`OFS_CTRL: begin
			rdata[`CTRL_ABILITY] <= correction_ability_flag;
			rdata[`CTRL_ENABLE] <= correction_enable_flag;
			rdata[`CTRL_ERR_REPORT] <= correction_error_report_flag;
		end
		`OFS_STATUS: begin
			rdata[`STAT_LOCK] <= fec_lock;
			rdata[`STAT_HIBER] <= high_error_rate;
			rdata[`STAT_FEC_PRESENT] <= fec_present;
			rdata[`STAT_ACTIVE] <= fec_on;
		end
		`OFS_INT_STATUS: begin
			// events of the setup cycle are included by the or below
			rdata[`INT_BITS-1:0] <= int_status | events;
		end
		`OFS_INT_MASK: begin
			rdata[`INT_BITS-1:0] <= int_mask;
		end
		`OFS_THRESH: begin
			rdata[TW-1:0] <= good_thresh;
			rdata[TW+7:8] <= bad_thresh;
		end
		`OFS_UNCORR_CNT: begin
			rdata[15:0] <= uncorr_cnt;
		end
		`OFS_HIBER_CFG: begin
			rdata[7:0] <= hiber_win;
			rdata[15:8] <= hiber_limit;
		end
		default: begin
			slverr <= 1'b1;
		end
		endcase
	end
end

assign pready_o = access;
assign prdata_o = (access & ~pwrite_i) ? rdata : 32'h00000000;
assign pslverr_o = access & slverr;

endmodule // fec_block_lock_options

// *** fec_block_lock_options_tb_top.sv ***
// testbench for the fec block lock option block.
// assumes default parameters and an apb master that waits at most 20 cycles for pready.
`timescale 1ns/1ps
`include "fec_lock_consts.vh"
module fec_block_lock_options_tb_top;
	logic mclk_i = 0, srst_i = 1, psel = 0, pen = 0, pwr = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, valid, good, unc, slip, sel, act, rep, lock;
	logic hib, irq;
	int num_errors = 0, check_count = 0, slips = 0, reps = 0;
	initial forever #50 mclk_i = ~mclk_i;
	fec_block_lock_options uut (.mclk_i(mclk_i), .srst_i(srst_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .blk_valid_i(valid), .parity_good_i(good),
		.uncorr_i(unc), .slip_o(slip), .soft_pcs_sel_o(sel),
		.correction_active_o(act), .err_report_o(rep), .block_lock_o(lock),
		.high_error_rate_status_o(hib), .irq_o(irq));
	fec_blk_src src (.clk_i(mclk_i), .valid_o(valid), .good_o(good),
		.uncorr_o(unc));
	always @(posedge mclk_i) begin
		if (slip) slips <= slips + 1;
		if (rep) reps <= reps + 1;
	end
	task summarize;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] x, input [31:0] g, input string nm);
		check_count++;
		if (g !== x) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, g);
		end
	endtask
	// answer and data are taken at the edge that samples pready high
	task apb(input logic w, input [7:0] a, input [31:0] d);
		int k;
		logic ok;
		k = 0;
		psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
		@(posedge mclk_i);
		pen <= 1;
		do begin
			@(posedge mclk_i);
			r = prdata;
			e = pslverr;
			ok = pready;
			k++;
		end while (ok !== 1'b1 && k < 20);
		if (ok !== 1'b1) begin
			num_errors++;
			summarize;
		end
		psel <= 0; pen <= 0;
		@(posedge mclk_i);
	endtask
	task rd(input [7:0] a, input [31:0] x, input string nm);
		apb(0, a, 32'h0);
		chk(x, r, nm);
	endtask
	initial begin
		repeat (20000) @(posedge mclk_i);
		num_errors++;
		summarize;
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		srst_i <= 0;
		@(posedge mclk_i);
		rd(`OFS_CTRL, 32'h7, "ctrl");
		rd(`OFS_STATUS, 32'hC, "status");
		chk(1, sel, "soft pcs");
		chk(1, act, "active");
		rd(`OFS_THRESH, 32'h804, "thresh");
		apb(0, 8'h1C, 32'h0);
		chk(1, e, "unmapped");
		apb(1, `OFS_INT_MASK, 32'hF);
		$display("reset test done");
		src.send(1, 0, 3);
		src.send(0, 0, 1);
		chk(1, slips, "hunt slip");
		src.send(1, 0, 3);
		chk(0, lock, "early lock");
		src.send(1, 0, 1);
		chk(1, lock, "lock");
		chk(1, irq, "irq");
		rd(`OFS_INT_STATUS, 32'h1, "gain status");
		chk(0, irq, "irq cleared");
		$display("lock test done");
		repeat (48) begin
			src.send(1, 0, 1);
			src.send(0, 0, 1);
		end
		chk(1, hib, "hiber");
		chk(1, lock, "lock kept");
		apb(1, `OFS_INT_MASK, 32'h0);
		src.send(1, 1, 1);
		chk(1, reps, "report");
		chk(0, irq, "masked");
		apb(1, `OFS_INT_MASK, 32'hF);
		chk(1, irq, "unmasked");
		rd(`OFS_UNCORR_CNT, 32'h1, "uncorr count");
		$display("error rate test done");
		src.send(0, 0, 7);
		chk(1, lock, "seven bad");
		src.send(0, 0, 1);
		chk(0, lock, "lock lost");
		chk(2, slips, "loss slip");
		chk(0, hib, "hiber off");
		rd(`OFS_INT_STATUS, 32'hE, "loss status");
		apb(1, `OFS_CTRL, 32'h5);
		chk(0, act, "disabled");
		src.send(1, 0, 4);
		chk(0, lock, "no lock off");
		apb(1, `OFS_CTRL, 32'h7);
		chk(1, act, "enabled");
		$display("loss test done");
		summarize;
	end
endmodule // fec_block_lock_options_tb_top

// *** fec_lock_consts.vh ***
// constants for the fec block lock option block: register offsets,
// field positions, reset values and default thresholds.
// assumes a 10 mhz core clock and an apb master with 32-bit data.
//
// Summary of operation
// - fec option selects soft pcs with correction
// - ability flag set at power-up, reset
// - enable flag set at power-up, reset
// - uncorrectable block errors reported onward to pcs
// - lock after good-parity threshold, default four
// - lose lock after bad-parity threshold, eight
// - optional lock and high error rate outputs
`ifndef FEC_LOCK_CONSTS_VH
`define FEC_LOCK_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_MASK 8'h0C
`define OFS_THRESH 8'h10
`define OFS_UNCORR_CNT 8'h14
`define OFS_HIBER_CFG 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_ABILITY 0
`define CTRL_ENABLE 1
`define CTRL_ERR_REPORT 2
`define STAT_LOCK 0
`define STAT_HIBER 1
`define STAT_FEC_PRESENT 2
`define STAT_ACTIVE 3
`define INT_LOCK_GAIN 0
`define INT_LOCK_LOSS 1
`define INT_UNCORR 2
`define INT_HIBER 3
`define INT_BITS 4

// ----------------------------------------
// reset values and defaults
// ----------------------------------------
`define GOOD_THRESH_DEF 4
`define BAD_THRESH_DEF 8
`define HIBER_WIN_DEF 8'h40
`define HIBER_LIMIT_DEF 8'h10
`define INT_MASK_RST 4'h0

`endif

// *** fec_lock_fsm.v ***
// block lock hunter for the receive fec path.
// assumes one blk_valid_i pulse per received fec block with its parity
// result alongside; slip_o asks the aligner to shift one bit position.
`timescale 1ns/1ps
module fec_lock_fsm #(
	parameter TW = 8
) (
	input wire mclk_i,
	input wire srst_i,
	input wire hold_i,
	input wire blk_valid_i,
	input wire parity_good_i,
	input wire [TW-1:0] good_thresh_i,
	input wire [TW-1:0] bad_thresh_i,
	output reg lock_o,
	output reg slip_o
);

localparam ST_HUNT = 1'b0;
localparam ST_LOCK = 1'b1;

reg state;
reg [TW-1:0] good_cnt;
reg [TW-1:0] bad_cnt;
wire [TW-1:0] good_next = good_cnt + {{(TW-1){1'b0}}, 1'b1};
wire [TW-1:0] bad_next = bad_cnt + {{(TW-1){1'b0}}, 1'b1};

// a threshold of zero acts as one, so lock is never free
always @(posedge mclk_i) begin
	slip_o <= 1'b0;
	if (srst_i || hold_i) begin
		state <= ST_HUNT;
		good_cnt <= {TW{1'b0}};
		bad_cnt <= {TW{1'b0}};
		lock_o <= 1'b0;
	end else if (blk_valid_i) begin
		case (state)
		ST_HUNT: begin
			if (parity_good_i) begin
				if (good_next >= good_thresh_i) begin
					state <= ST_LOCK;
					lock_o <= 1'b1;
					good_cnt <= {TW{1'b0}};
				end else begin
					good_cnt <= good_next;
				end
			end else begin
				slip_o <= 1'b1;
				good_cnt <= {TW{1'b0}};
			end
			bad_cnt <= {TW{1'b0}};
		end
		ST_LOCK: begin
			if (parity_good_i) begin
				bad_cnt <= {TW{1'b0}};
			end else if (bad_next >= bad_thresh_i) begin
				state <= ST_HUNT;
				lock_o <= 1'b0;
				bad_cnt <= {TW{1'b0}};
				slip_o <= 1'b1;
			end else begin
				bad_cnt <= bad_next;
			end
		end
		default: begin
			state <= ST_HUNT;
			lock_o <= 1'b0;
		end
		endcase
	end
end

endmodule // fec_lock_fsm

// *** fec_lock_monitor.sv ***
// checker for the fec block lock option block.
// assumes default option parameters and one clock with sync reset.
`timescale 1ns/1ps
module fec_lock_monitor #(
	parameter int GOOD = 4,
	parameter int BAD = 8
) (
	input wire mclk_i,
	input wire srst_i,
	input wire blk_valid_i,
	input wire parity_good_i,
	input wire uncorr_i,
	input wire slip_o,
	input wire soft_pcs_sel_o,
	input wire correction_active_o,
	input wire err_report_o,
	input wire block_lock_o,
	input wire high_error_rate_status_o
);
	// ----------------------------------------
	// run counters of accepted blocks
	// ----------------------------------------
	logic [7:0] good_run;
	logic [7:0] bad_run;
	wire take = blk_valid_i & correction_active_o;
	always @(posedge mclk_i) begin
		if (srst_i) begin
			good_run <= 8'h00;
			bad_run <= 8'h00;
		end else if (take) begin
			good_run <= parity_good_i ? good_run + 8'h01 : 8'h00;
			bad_run <= parity_good_i ? 8'h00 : bad_run + 8'h01;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	soft_sel_a: assert property (soft_pcs_sel_o)
		else $error("soft pcs not selected");
	act_rst_a: assert property ($fell(srst_i) |-> correction_active_o)
		else $error("correction not active after reset");
	err_rep_a: assert property (take & uncorr_i |=> err_report_o)
		else $error("uncorrectable block not reported");
	err_cause_a: assert property (err_report_o |-> $past(take & uncorr_i))
		else $error("report without uncorrectable block");
	lock_gain_a: assert property ($rose(block_lock_o) |-> good_run >= GOOD)
		else $error("lock gained too early");
	lock_loss_a: assert property ($fell(block_lock_o) && correction_active_o
		|-> bad_run >= BAD && slip_o)
		else $error("lock lost wrongly");
	slip_hunt_a: assert property (take & !parity_good_i & !block_lock_o |=> slip_o)
		else $error("no slip after bad block in hunt");
	hiber_lock_a: assert property ($rose(high_error_rate_status_o) |-> block_lock_o)
		else $error("high error rate without lock");
	gain_c: cover property ($rose(block_lock_o));
	loss_c: cover property ($fell(block_lock_o));
	hiber_c: cover property ($rose(high_error_rate_status_o));
endmodule // fec_lock_monitor
bind fec_block_lock_options fec_lock_monitor #(.GOOD(GOOD_THRESH),
	.BAD(BAD_THRESH)) mon (.mclk_i(mclk_i), .srst_i(srst_i),
	.blk_valid_i(blk_valid_i), .parity_good_i(parity_good_i),
	.uncorr_i(uncorr_i), .slip_o(slip_o), .soft_pcs_sel_o(soft_pcs_sel_o),
	.correction_active_o(correction_active_o), .err_report_o(err_report_o),
	.block_lock_o(block_lock_o),
	.high_error_rate_status_o(high_error_rate_status_o));
